// ===== verilog/bax_alu.sv
// Byte ALU slice: register-minus-acc, xor, nibble exchange, literal xor.
// Assumes a file register memory with one-cycle registered read and an AHB-Lite master.
`timescale 1ns/1ns
`default_nettype none
module bax_alu
	import bax_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	// File register memory
	output bax_pkg::bax_file_req_t      file_req,
	input  wire logic [7:0]             file_rdata,
	// Status
	output logic                        busy
);
	import bax_pkg::*;

	bax_state_t st;
	bax_state_t next_st;

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction : is_zero

	function automatic logic [31:0] reg_read(input bax_state_t s, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			BAX_OFF_CMD:
			begin
				d[BAX_CMD_OP_LSB +: 2]   = s.op;
				d[BAX_CMD_DEST_BIT]      = s.dest;
				d[BAX_CMD_ADDR_LSB +: 7] = s.file.addr;
				d[BAX_CMD_LIT_LSB +: 8]  = s.lit;
			end
			BAX_OFF_ACC:  d[7:0] = s.acc;
			BAX_OFF_STAT:
			begin
				d[BAX_STAT_C_BIT]    = s.flags.c;
				d[BAX_STAT_NB_BIT]   = s.flags.nibble_borrow_flag;
				d[BAX_STAT_Z_BIT]    = s.flags.z;
				d[BAX_STAT_BUSY_BIT] = (s.fsm != BAX_ST_IDLE);
			end
			BAX_OFF_RES:  d[7:0] = s.result;
			default:      d = 32'h0000_0000;
		endcase
		reg_read = d;
	endfunction : reg_read

	always_comb
	begin
		logic [7:0] opnd;
		logic [7:0] res;
		opnd = 8'h00;
		res  = 8'h00;
		next_st = st;
		next_st.file.wr = 1'b0;
		// Data phase of a write
		if (st.ph_wr && st.ph_hit && st.fsm == BAX_ST_IDLE)
		begin
			case (st.ph_addr)
				BAX_OFF_CMD:
				begin
					next_st.op        = bax_op_t'(hwdata[BAX_CMD_OP_LSB +: 2]);
					next_st.dest      = hwdata[BAX_CMD_DEST_BIT];
					next_st.file.addr = hwdata[BAX_CMD_ADDR_LSB +: 7];
					next_st.lit       = hwdata[BAX_CMD_LIT_LSB +: 8];
					if (bax_op_t'(hwdata[BAX_CMD_OP_LSB +: 2]) == BAX_OP_LXOR)
					begin
						next_st.fsm = BAX_ST_EX;
					end
					else
					begin
						next_st.fsm     = BAX_ST_RD;
						next_st.file.rd = 1'b1;
					end
				end
				BAX_OFF_ACC:  next_st.acc = hwdata[7:0];
				BAX_OFF_STAT:
				begin
					next_st.flags.c                  = hwdata[BAX_STAT_C_BIT];
					next_st.flags.nibble_borrow_flag = hwdata[BAX_STAT_NB_BIT];
					next_st.flags.z                  = hwdata[BAX_STAT_Z_BIT];
				end
				default: ;
			endcase
		end
		// Operation sequencer
		case (st.fsm)
			BAX_ST_IDLE: ;
			BAX_ST_RD:
			begin
				next_st.file.rd = 1'b0;
				next_st.fsm     = BAX_ST_EX;
			end
			BAX_ST_EX:
			begin
				opnd = file_rdata;
				case (st.op)
					BAX_OP_SUB:
					begin
						res = opnd - st.acc;
						next_st.flags.c = (st.acc <= opnd);
						next_st.flags.nibble_borrow_flag = (st.acc[3:0] <= opnd[3:0]);
						next_st.flags.z = is_zero(res);
					end
					BAX_OP_XOR:
					begin
						res = st.acc ^ opnd;
						next_st.flags.z = is_zero(res);
					end
					BAX_OP_SWAP:  res = {opnd[3:0], opnd[7:4]};
					BAX_OP_LXOR:
					begin
						res = st.acc ^ st.lit;
						next_st.flags.z = is_zero(res);
					end
					default:      res = 8'h00;
				endcase
				next_st.result = res;
				if (st.dest && st.op != BAX_OP_LXOR)
				begin
					next_st.file.wr    = 1'b1;
					next_st.file.wdata = res;
					next_st.fsm        = BAX_ST_WR;
				end
				else
				begin
					next_st.acc = res;
					next_st.fsm = BAX_ST_IDLE;
				end
			end
			BAX_ST_WR:    next_st.fsm = BAX_ST_IDLE;
			default:      next_st.fsm = BAX_ST_IDLE;
		endcase
		// Busy output held in a flop
		next_st.busy = (next_st.fsm != BAX_ST_IDLE);
		// Address phase capture
		next_st.ph_wr = 1'b0;
		if (hsel && htrans[1] && hready)
		begin
			next_st.ph_wr   = hwrite;
			next_st.ph_hit  = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
			next_st.ph_addr = haddr[7:0];
			if (!hwrite)
			begin
				next_st.hrdata = (next_st.ph_hit) ? reg_read(next_st, haddr[7:0]) : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st       <= '0;
			st.fsm   <= BAX_ST_IDLE;
			st.op    <= BAX_OP_SUB;
			st.acc   <= BAX_ACC_RST;
			st.flags <= BAX_FLG_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = st.hrdata;
	assign file_req  = st.file;
	assign busy      = st.busy;
endmodule : bax_alu
`default_nettype wire

// ===== shared/bax_pkg.sv
// Shared constants and types for the byte ALU slice.
// Assumes a single 250 MHz core clock and an AHB-Lite register port.
package bax_pkg;
	// Register byte offsets
	localparam logic [7:0] BAX_OFF_CMD  = 8'h00;
	localparam logic [7:0] BAX_OFF_ACC  = 8'h04;
	localparam logic [7:0] BAX_OFF_STAT = 8'h08;
	localparam logic [7:0] BAX_OFF_RES  = 8'h0c;
	// Command word fields
	localparam int BAX_CMD_OP_LSB   = 0;
	localparam int BAX_CMD_DEST_BIT = 2;
	localparam int BAX_CMD_ADDR_LSB = 8;
	localparam int BAX_CMD_LIT_LSB  = 16;
	// Status word fields
	localparam int BAX_STAT_C_BIT    = 0;
	localparam int BAX_STAT_NB_BIT   = 1;
	localparam int BAX_STAT_Z_BIT    = 2;
	localparam int BAX_STAT_BUSY_BIT = 8;
	// Reset values
	localparam logic [7:0] BAX_ACC_RST = 8'h00;
	localparam logic [2:0] BAX_FLG_RST = 3'h0;

	typedef enum logic [1:0] {
		BAX_OP_SUB  = 2'b00,
		BAX_OP_XOR  = 2'b01,
		BAX_OP_SWAP = 2'b10,
		BAX_OP_LXOR = 2'b11
	} bax_op_t;

	typedef enum logic [1:0] {
		BAX_ST_IDLE = 2'b00,
		BAX_ST_RD   = 2'b01,
		BAX_ST_EX   = 2'b10,
		BAX_ST_WR   = 2'b11
	} bax_fsm_t;

	typedef struct packed {
		logic       c;
		logic       nibble_borrow_flag;
		logic       z;
	} bax_flags_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} bax_file_req_t;

	typedef struct packed {
		bax_fsm_t      fsm;
		bax_op_t       op;
		logic          dest;
		logic [7:0]    lit;
		logic [7:0]    acc;
		bax_flags_t    flags;
		logic [7:0]    result;
		bax_file_req_t file;
		logic          ph_wr;
		logic          ph_hit;
		logic [7:0]    ph_addr;
		logic [31:0]   hrdata;
		logic          busy;
	} bax_state_t;
endpackage : bax_pkg

// ===== dv/bax_alu_assertions.sv
// Port checker for the byte ALU slice
// Assumes binding onto bax_alu
`timescale 1ns/1ns
`default_nettype none
module bax_chk
	import bax_pkg::*;
(
	// Watched ports
	input wire logic                  clk,
	input wire logic                  srst,
	input wire logic                  hresp,
	input wire logic [31:0]           hrdata,
	input wire bax_pkg::bax_file_req_t file_req,
	input wire logic                  busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_bus_okay: assert property (!hresp) else $error("bad resp");
	a_upper_zero: assert property (hrdata[31:24] == 8'h00) else $error("upper bits set");
	a_rd_pulse: assert property (file_req.rd |=> !file_req.rd) else $error("long rd");
	a_rd_busy: assert property (file_req.rd |-> busy) else $error("rd while idle");
	a_rd_finish: assert property (file_req.rd |-> ##2 (file_req.wr || !busy)) else $error("late end");
	a_wr_source: assert property (file_req.wr |-> $past(file_req.rd, 2) && $stable(file_req.addr))
		else $error("bad wr");
	a_wr_release: assert property (file_req.wr |-> busy ##1 !busy) else $error("busy after wr");
	a_idle_quiet: assert property (!busy |-> !file_req.rd && !file_req.wr) else $error("idle access");
endmodule : bax_chk
bind bax_alu bax_chk u_chk (.clk(clk), .srst(srst), .hresp(hresp), .hrdata(hrdata), .file_req(file_req),
	.busy(busy));
`default_nettype wire

// ===== dv/bax_file_model.sv
// File register memory model
// Assumes one-cycle registered read
`timescale 1ns/1ns
`default_nettype none
module bax_file_model
	import bax_pkg::*;
(
	input wire logic                   clk,
	input wire bax_pkg::bax_file_req_t file_req,
	output logic [7:0]                 file_rdata
);
	logic [7:0] mem [128];
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
	initial file_rdata = 8'h00;
	// Stale data inverted when not read
	always @(posedge clk)
	begin
		file_rdata <= file_req.rd ? mem[file_req.addr] : ~file_rdata;
		if (file_req.wr)
			mem[file_req.addr] <= file_req.wdata;
	end
endmodule : bax_file_model
`default_nettype wire

// ===== dv/byte_alu_sub_xor_swap_test.sv
// Self-checking bench for the ALU slice
// Assumes file model and zero-wait slave
`timescale 1ns/1ns
`default_nettype none
module byte_alu_sub_xor_swap_test;
	import bax_pkg::*;
	logic clk = 0, srst = 1, hw = 0, rdy, resp, busy;
	logic [31:0] ha = 0, hwd = 0, hrd;
	logic [1:0] ht = 0;
	logic [7:0] frd;
	bax_file_req_t req;
	int n_fail = 0, n_compared = 0, cyc = 0;
	always #2 clk = ~clk;
	always @(posedge clk)
		if (++cyc == 3000)
		begin
			n_fail++;
			stop_test;
		end
	bax_alu DUT (.clk(clk), .srst(srst), .hsel(1'b1), .haddr(ha), .htrans(ht), .hwrite(hw), .hsize(3'h2),
		.hwdata(hwd), .hready(rdy), .hreadyout(rdy), .hresp(resp), .hrdata(hrd), .file_req(req),
		.file_rdata(frd), .busy(busy));
	bax_file_model m (.clk(clk), .file_req(req), .file_rdata(frd));
	task automatic chk(string s, logic [31:0] g, e);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
		ha <= {24'h0, a};
		ht <= 2'h2;
		hw <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		ht <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		q = hrd;
	endtask : bus
	task automatic t_op(logic [1:0] op, logic dst, logic [6:0] a, logic [7:0] w, k, logic [2:0] s0);
		logic [7:0] f, r;
		logic [2:0] s;
		logic [31:0] q;
		logic de;
		f = m.mem[a];
		s = s0;
		de = dst && op != 2'h3;
		case (op)
			2'h0: r = f - w;
			2'h1: r = f ^ w;
			2'h2: r = {f[3:0], f[7:4]};
			default: r = w ^ k;
		endcase
		if (op == 2'h0)
			s[1:0] = {w[3:0] <= f[3:0], w <= f};
		if (op != 2'h2)
			s[2] = r == 8'h00;
		bus(1, BAX_OFF_ACC, {24'h0, w}, q);
		bus(1, BAX_OFF_STAT, {29'h0, s0}, q);
		bus(1, BAX_OFF_CMD, {8'h0, k, 1'b0, a, 5'h0, dst, op}, q);
		q = 32'h100;
		for (int i = 0; i < 50 && q[8]; i++)
			bus(0, BAX_OFF_STAT, 0, q);
		chk("stat", q, {29'h0, s});
		chk("busy", {31'h0, busy}, 0);
		chk("resp", {31'h0, resp}, 0);
		bus(0, BAX_OFF_ACC, 0, q);
		chk("acc", q, {24'h0, de ? w : r});
		chk("file", {24'h0, m.mem[a]}, {24'h0, de ? r : f});
	endtask : t_op
	task automatic t_reset;
		logic [31:0] q;
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		chk("busy reset", {31'h0, busy}, 0);
		bus(0, BAX_OFF_ACC, 0, q);
		chk("acc reset", q, 0);
		bus(0, BAX_OFF_STAT, 0, q);
		chk("stat reset again", q, 0);
	endtask : t_reset
	task automatic stop_test;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	initial
	begin
		logic [31:0] q;
		repeat (2) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		bus(0, BAX_OFF_STAT, 0, q);
		chk("stat reset", q, 0);
		bus(1, 8'h10, '1, q);
		bus(0, 8'h10, 0, q);
		chk("unmapped", q, 0);
		t_op(0, 0, 5, 8'h5f, 0, 0);
		t_op(0, 1, 7, 8'hff, 0, 7);
		t_op(0, 0, 2, 8'h09, 0, 0);
		t_op(1, 1, 9, 8'h53, 0, 3);
		t_op(1, 0, 127, 8'h0f, 0, 4);
		t_op(2, 1, 3, 8'h11, 0, 5);
		t_op(2, 0, 0, 8'h22, 0, 2);
		t_reset;
		t_op(3, 1, 0, 8'ha5, 8'ha5, 3);
		t_op(3, 0, 0, 8'h0f, 8'hff, 4);
		stop_test;
	end
endmodule : byte_alu_sub_xor_swap_test
`default_nettype wire
